// ### logic/ldc_bank.sv
// Configuration register bank for logical devices 3 to 8.
`timescale 1ns/100ps
module ldc_bank (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        vcc_por,
    input  wire logic        vtr_por,
    input  wire logic        vbat_por,
    input  wire logic        soft_reset,
    input  wire logic        cfg_mode,
    input  wire logic [7:0]  ldn,
    input  wire logic [7:0]  index,
    input  wire logic        wr_strobe,
    input  wire logic [7:0]  wr_data,
    input  wire logic        rd_strobe,
    input  wire logic [2:0]  shadow_load,
    input  wire logic [23:0] shadow_data,
    output logic      [7:0]  rd_data,
    output logic             rd_valid,
    output logic      [5:0]  dev_active,
    output logic      [15:0] par_base_addr,
    output logic      [7:0]  par_mode,
    output logic      [15:0] infrared_base_addr,
    output logic      [7:0]  infrared_duplex_timeout,
    output logic      [7:0]  floppy_write_protect_force
);
    import ldc_pkg::*;

    // ----------------------------------------------------------------
    // Access qualification
    // ----------------------------------------------------------------
    logic [4:0]  rst_vec;
    logic        wr_ok;
    logic        rd_ok;
    logic [7:0]  reg_value [LDC_COUNT];
    logic [LDC_COUNT-1:0] hit;
    logic [7:0]  rd_part [LDC_COUNT];
    logic [7:0]  shadow_value [LDC_SHADOWS];
    logic [LDC_SHADOWS-1:0] shadow_hit;
    logic [7:0]  shadow_part [LDC_SHADOWS];
    logic [7:0]  next_rd_data;
    logic        any_hit;

    assign rst_vec = {soft_reset, vbat_por, vtr_por, vcc_por, reset};
    // Outside configuration mode the ports are dead to the host.
    assign wr_ok = wr_strobe && cfg_mode;
    assign rd_ok = rd_strobe && cfg_mode;

    // ----------------------------------------------------------------
    // Register entries
    // ----------------------------------------------------------------
    // Each entry resets only on the sources in its class, so battery backed
    // entries ride through hard reset and both supply PORs.
    generate
        for (genvar i = 0; i < LDC_COUNT; i++) begin : g_reg
            localparam ldc_entry_type ENT = LDC_TABLE[i];
            logic       rst_hit;
            logic [7:0] next_val;
            assign hit[i] = (ldn == ENT[28:21]) && (index == ENT[20:13]);
            assign rst_hit = |(rst_vec & ENT[4:0]);
            assign next_val = rst_hit ? ENT[12:5]
                            : (wr_ok && hit[i]) ? wr_data : reg_value[i];
            always_ff @(posedge clk_sys) begin
                reg_value[i] <= next_val;
            end
            assign rd_part[i] = hit[i] ? reg_value[i] : 8'h00;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Shadows of write-only function registers
    // ----------------------------------------------------------------
    // Only the function core loads a shadow; the host data path has no
    // route into these flops at all.
    generate
        for (genvar s = 0; s < LDC_SHADOWS; s++) begin : g_shadow
            logic [7:0] next_shadow;
            assign shadow_hit[s] = (ldn == LDC_LD_AUX)
                                 && (index == LDC_SHADOW_BASE + 8'(s));
            assign next_shadow = (|(rst_vec & LDC_SHADOW_CLASS)) ? LDC_SHADOW_RESET
                               : shadow_load[s] ? shadow_data[s*8 +: 8]
                               : shadow_value[s];
            always_ff @(posedge clk_sys) begin
                shadow_value[s] <= next_shadow;
            end
            assign shadow_part[s] = shadow_hit[s] ? shadow_value[s] : 8'h00;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Unmatched indices contribute nothing, so they read as zero.
    always_comb begin
        next_rd_data = 8'h00;
        for (int k = 0; k < LDC_COUNT; k++) begin
            next_rd_data = next_rd_data | rd_part[k];
        end
        for (int k = 0; k < LDC_SHADOWS; k++) begin
            next_rd_data = next_rd_data | shadow_part[k];
        end
    end

    assign any_hit = (|hit) || (|shadow_hit);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_ok;
            if (rd_ok) begin
                rd_data <= next_rd_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // Configuration outputs
    // ----------------------------------------------------------------
    assign dev_active = {reg_value[E_AUX_ACT][0], reg_value[E_KBD_ACT][0],
                         reg_value[E_CLK_ACT][0], reg_value[E_SER2_ACT][0],
                         reg_value[E_SER1_ACT][0], reg_value[E_PAR_ACT][0]};
    // The lower index holds the upper byte of each base pair.
    assign par_base_addr = {reg_value[E_PAR_BASE_HI], reg_value[E_PAR_BASE_LO]};
    assign par_mode = reg_value[E_PAR_MODE];
    assign infrared_base_addr = {reg_value[E_IR_BASE_HI], reg_value[E_IR_BASE_LO]};
    assign infrared_duplex_timeout = reg_value[E_IR_TIMEOUT];
    assign floppy_write_protect_force = reg_value[E_FWP];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic wr_none;
    assign wr_none = !wr_ok;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_par_mode_boot: assert property (
        $past(reset) |-> par_mode == 8'h3C && reg_value[E_PAR_DMA] == 8'h04)
        else $error("parallel mode or DMA select wrong after hard reset");

    a_par_mode_soft: assert property (
        soft_reset && !vcc_por && !vtr_por && wr_none |=> $stable(par_mode))
        else $error("soft reset altered parallel mode register");

    a_timeout_load: assert property (
        (vcc_por || vtr_por) |=> infrared_duplex_timeout == 8'h03)
        else $error("duplex timeout not loaded by supply reset");

    a_timeout_soft: assert property (
        soft_reset && !vcc_por && !vtr_por && wr_none
        |=> $stable(infrared_duplex_timeout))
        else $error("soft reset altered duplex timeout");

    a_ir_base_clear: assert property (
        (soft_reset || vcc_por || vtr_por) |=> infrared_base_addr == 16'h0000)
        else $error("infrared base not cleared");

    a_rate_shadow: assert property (
        shadow_load[0] && !vcc_por ##1 rd_ok && shadow_hit[0] && !shadow_load[0]
        |=> rd_valid && rd_data == $past(shadow_data[7:0], 2))
        else $error("rate shadow read does not match last load");

    a_fwp_trickle: assert property (
        vtr_por && !vcc_por && wr_none |=> $stable(floppy_write_protect_force))
        else $error("trickle reset altered force write protect");

    a_battery_keep: assert property (
        (vcc_por || vtr_por || soft_reset) && !vbat_por && wr_none
        |=> $stable(reg_value[E_GPIO_50]))
        else $error("battery backed register changed without battery reset");

    a_base_order: assert property (
        wr_ok && ldn == LDC_LD_PAR && index == 8'h60 && rst_vec == 5'h00
        |=> par_base_addr[15:8] == $past(wr_data))
        else $error("high byte of base pair misplaced");

    a_unmapped_zero: assert property (
        rd_ok && !any_hit |=> rd_valid && rd_data == 8'h00)
        else $error("unmapped read returned nonzero");

    a_shadow_locked: assert property (
        wr_ok && shadow_hit[0] && !shadow_load[0] && rst_vec == 5'h00
        |=> $stable(shadow_value[0]))
        else $error("host write changed a shadow");

    // ----------------------------------------------------------------
    // Per-register checks
    // ----------------------------------------------------------------
    // Each output except dev_active bits 1 to 5 is pinned to its reset class and to its one write path, so a
    // misnumbered table position fires a check instead of miswiring quietly.
    logic quiet;
    assign quiet = (rst_vec == 5'h00);

    a_par_dma_soft: assert property (
        soft_reset |=> reg_value[E_PAR_DMA] == 8'h04)
        else $error("soft reset did not restore parallel DMA select");

    a_par_mode_load: assert property (
        (vcc_por || vtr_por) |=> par_mode == 8'h3C)
        else $error("supply reset did not load parallel mode");

    a_par_mode_write: assert property (
        wr_ok && hit[E_PAR_MODE] && quiet |=> par_mode == $past(wr_data))
        else $error("parallel mode write lost");

    a_par_mode_idle: assert property (
        quiet && !(wr_ok && hit[E_PAR_MODE]) |=> $stable(par_mode))
        else $error("parallel mode changed without a write");

    a_par_base_soft: assert property (
        soft_reset |=> par_base_addr == 16'h0000)
        else $error("soft reset did not clear parallel base");

    a_par_act_soft: assert property (
        soft_reset |=> !dev_active[0])
        else $error("soft reset did not clear parallel activate");

    a_par_act_write: assert property (
        wr_ok && hit[E_PAR_ACT] && quiet |=> dev_active[0] == $past(wr_data[0]))
        else $error("parallel activate write lost");

    a_read_mode: assert property (
        rd_ok && hit[E_PAR_MODE] |=> rd_data == $past(par_mode))
        else $error("parallel mode read back wrong");

    a_timeout_boot: assert property (
        $past(reset) |-> infrared_duplex_timeout == 8'h03)
        else $error("duplex timeout wrong after hard reset");

    a_timeout_write: assert property (
        wr_ok && hit[E_IR_TIMEOUT] && quiet |=> infrared_duplex_timeout == $past(wr_data))
        else $error("duplex timeout write lost");

    a_timeout_hold: assert property (
        quiet && !(wr_ok && hit[E_IR_TIMEOUT]) |=> $stable(infrared_duplex_timeout))
        else $error("duplex timeout changed without a write");

    a_timeout_battery: assert property (
        vbat_por && !vcc_por && !vtr_por && wr_none
        |=> $stable(infrared_duplex_timeout))
        else $error("battery reset altered duplex timeout");

    a_read_timeout: assert property (
        rd_ok && hit[E_IR_TIMEOUT] |=> rd_data == $past(infrared_duplex_timeout))
        else $error("duplex timeout read back wrong");

    a_ir_base_boot: assert property (
        $past(reset) |-> infrared_base_addr == 16'h0000)
        else $error("infrared base not cleared by hard reset");

    a_ir_base_hold: assert property (
        quiet && !(wr_ok && (hit[E_IR_BASE_HI] || hit[E_IR_BASE_LO]))
        |=> $stable(infrared_base_addr))
        else $error("infrared base changed without a write");

    a_ir_high_byte: assert property (
        wr_ok && hit[E_IR_BASE_HI] && quiet |=> infrared_base_addr[15:8] == $past(wr_data))
        else $error("high byte of infrared base misplaced");

    a_ir_low_byte: assert property (
        wr_ok && hit[E_IR_BASE_LO] && quiet |=> infrared_base_addr[7:0] == $past(wr_data))
        else $error("low byte of infrared base misplaced");

    a_par_low_byte: assert property (
        wr_ok && hit[E_PAR_BASE_LO] && quiet |=> par_base_addr[7:0] == $past(wr_data))
        else $error("low byte of parallel base misplaced");

    a_par_base_hold: assert property (
        quiet && !(wr_ok && (hit[E_PAR_BASE_HI] || hit[E_PAR_BASE_LO]))
        |=> $stable(par_base_addr))
        else $error("parallel base changed without a write");

    a_read_ir_base: assert property (
        rd_ok && hit[E_IR_BASE_HI] |=> rd_data == $past(infrared_base_addr[15:8]))
        else $error("infrared base high byte read back wrong");

    a_read_par_base: assert property (
        rd_ok && hit[E_PAR_BASE_HI] |=> rd_data == $past(par_base_addr[15:8]))
        else $error("parallel base high byte read back wrong");

    a_rate_clear: assert property (
        vcc_por |=> shadow_value[0] == LDC_SHADOW_RESET)
        else $error("rate shadow not cleared by main supply reset");

    a_fwp_clear: assert property (
        vcc_por |=> floppy_write_protect_force == 8'h00)
        else $error("force write protect not cleared by main supply reset");

    a_fwp_soft: assert property (
        soft_reset && !vcc_por && wr_none |=> $stable(floppy_write_protect_force))
        else $error("soft reset altered force write protect");

    a_fwp_write: assert property (
        wr_ok && hit[E_FWP] && quiet |=> floppy_write_protect_force == $past(wr_data))
        else $error("force write protect write lost");

    a_fwp_hold: assert property (
        quiet && !(wr_ok && hit[E_FWP]) |=> $stable(floppy_write_protect_force))
        else $error("force write protect changed without a write");

    a_read_fwp: assert property (
        rd_ok && hit[E_FWP] |=> rd_data == $past(floppy_write_protect_force))
        else $error("force write protect read back wrong");

    a_battery_default: assert property (
        vbat_por |=> reg_value[E_GPIO_50] == 8'h01)
        else $error("battery reset did not load pin configuration");

    a_gpio_write: assert property (
        wr_ok && hit[E_GPIO_50] && quiet |=> reg_value[E_GPIO_50] == $past(wr_data))
        else $error("pin configuration write lost");

    a_read_gpio: assert property (
        rd_ok && hit[E_GPIO_50] |=> rd_data == $past(reg_value[E_GPIO_50]))
        else $error("pin configuration read back wrong");

    a_read_answer: assert property (
        rd_ok |=> rd_valid)
        else $error("accepted read gave no answer");

    a_read_blocked: assert property (
        rd_strobe && !cfg_mode |=> !rd_valid && $stable(rd_data))
        else $error("read outside configuration mode was answered");

    a_write_blocked: assert property (
        wr_strobe && !cfg_mode && quiet
        |=> $stable(par_mode) && $stable(floppy_write_protect_force))
        else $error("write outside configuration mode took effect");

    // Every shadow follows its core load and nothing else.
    generate
        for (genvar s = 0; s < LDC_SHADOWS; s++) begin : g_shadow_chk
            a_shadow_load: assert property (@(posedge clk_sys) disable iff (reset)
                shadow_load[s] && !vcc_por |=> shadow_value[s] == $past(shadow_data[s*8 +: 8]))
                else $error("shadow did not take the core load");

            a_shadow_hold: assert property (@(posedge clk_sys) disable iff (reset)
                !shadow_load[s] && !vcc_por |=> $stable(shadow_value[s]))
                else $error("shadow changed without a core load");
        end
    endgenerate

    c_mapped_read: cover property (rd_ok && |hit ##1 rd_valid);
    c_gpio_write: cover property (wr_ok && hit[E_GPIO_50]);
    c_shadow_read: cover property (shadow_load[1] ##[1:20] rd_ok && shadow_hit[1]);
    c_blocked_write: cover property (wr_strobe && !cfg_mode);
    c_battery_reset: cover property (vbat_por && !vcc_por);
endmodule

// ### logic/ldc_pkg.sv
// Constants and register table of the logical device configuration bank.
// Summary of operation
// - Parallel port group; first mode register defaults 0x3C and survives soft reset.
// - Infrared half duplex timeout loads 0x03 on hard and supply resets only.
// - Consumer infrared base pair clears on hard, supply and soft reset.
// - Floppy data rate shadow returns the value last written by the core.
// - Floppy force write protect clears on hard and main POR, not trickle.
// - Battery backed registers take defaults only at battery power-on reset.
// - Lower index of a base pair is the high byte, higher the low.
// - Unimplemented registers ignore writes and read as zero.
package ldc_pkg;
    // ----------------------------------------------------------------
    // Logical device numbers and reset classes
    // ----------------------------------------------------------------
    localparam logic [7:0] LDC_LD_PAR = 8'h03;
    localparam logic [7:0] LDC_LD_SER1 = 8'h04;
    localparam logic [7:0] LDC_LD_SER2 = 8'h05;
    localparam logic [7:0] LDC_LD_CLK = 8'h06;
    localparam logic [7:0] LDC_LD_KBD = 8'h07;
    localparam logic [7:0] LDC_LD_AUX = 8'h08;
    // Class bits: 0 hard, 1 main POR, 2 trickle POR, 3 battery POR, 4 soft.
    localparam logic [4:0] C_HVTS = 5'h17;
    localparam logic [4:0] C_HVT = 5'h07;
    localparam logic [4:0] C_HV = 5'h03;
    localparam logic [4:0] C_T = 5'h04;
    localparam logic [4:0] C_B = 5'h08;
    localparam logic [4:0] LDC_SHADOW_CLASS = 5'h03;
    localparam logic [7:0] LDC_SHADOW_RESET = 8'h00;
    localparam logic [7:0] LDC_SHADOW_BASE = 8'hC2;
    localparam int LDC_SHADOWS = 3;
    // ----------------------------------------------------------------
    // Table: device, index, reset value, class
    // ----------------------------------------------------------------
    typedef logic [28:0] ldc_entry_type;
    localparam int LDC_COUNT = 54;
    localparam ldc_entry_type LDC_TABLE [LDC_COUNT] = '{
        {LDC_LD_PAR, 8'h30, 8'h00, C_HVTS}, {LDC_LD_PAR, 8'h60, 8'h00, C_HVTS},
        {LDC_LD_PAR, 8'h61, 8'h00, C_HVTS}, {LDC_LD_PAR, 8'h70, 8'h00, C_HVTS},
        {LDC_LD_PAR, 8'h74, 8'h04, C_HVTS}, {LDC_LD_PAR, 8'hF0, 8'h3C, C_HVT},
        {LDC_LD_PAR, 8'hF1, 8'h00, C_HVT},
        {LDC_LD_SER1, 8'h30, 8'h00, C_HVTS}, {LDC_LD_SER1, 8'h60, 8'h00, C_HVTS},
        {LDC_LD_SER1, 8'h61, 8'h00, C_HVTS}, {LDC_LD_SER1, 8'h70, 8'h00, C_HVTS},
        {LDC_LD_SER1, 8'hF0, 8'h00, C_HVT},
        {LDC_LD_SER2, 8'h30, 8'h00, C_T}, {LDC_LD_SER2, 8'h60, 8'h00, C_HVTS},
        {LDC_LD_SER2, 8'h61, 8'h00, C_HVTS}, {LDC_LD_SER2, 8'h62, 8'h00, C_HVTS},
        {LDC_LD_SER2, 8'h63, 8'h00, C_HVTS}, {LDC_LD_SER2, 8'h70, 8'h00, C_HVTS},
        {LDC_LD_SER2, 8'h74, 8'h04, C_HVTS}, {LDC_LD_SER2, 8'hF0, 8'h00, C_HVT},
        {LDC_LD_SER2, 8'hF1, 8'h02, C_HVT}, {LDC_LD_SER2, 8'hF2, 8'h03, C_HVT},
        {LDC_LD_CLK, 8'h30, 8'h00, C_HVTS}, {LDC_LD_CLK, 8'h62, 8'h00, C_HVTS},
        {LDC_LD_CLK, 8'h63, 8'h70, C_HVTS}, {LDC_LD_CLK, 8'h70, 8'h00, C_HVTS},
        {LDC_LD_CLK, 8'hF0, 8'h00, C_HV},
        {LDC_LD_KBD, 8'h30, 8'h00, C_HVTS}, {LDC_LD_KBD, 8'h70, 8'h00, C_HVTS},
        {LDC_LD_KBD, 8'h72, 8'h00, C_HVTS}, {LDC_LD_KBD, 8'hF0, 8'h00, C_HVT},
        {LDC_LD_AUX, 8'h30, 8'h00, C_HVTS}, {LDC_LD_AUX, 8'hB0, 8'h00, C_B},
        {LDC_LD_AUX, 8'hB1, 8'h80, C_B}, {LDC_LD_AUX, 8'hB2, 8'h00, C_B},
        {LDC_LD_AUX, 8'hB3, 8'h00, C_B}, {LDC_LD_AUX, 8'hB8, 8'h00, C_T},
        {LDC_LD_AUX, 8'hC0, 8'h00, C_B}, {LDC_LD_AUX, 8'hC1, 8'h01, C_HV},
        {LDC_LD_AUX, 8'hC5, 8'h00, C_HV}, {LDC_LD_AUX, 8'hC6, 8'h00, C_B},
        {LDC_LD_AUX, 8'hC8, 8'h01, C_B}, {LDC_LD_AUX, 8'hCA, 8'h09, C_B},
        {LDC_LD_AUX, 8'hCB, 8'h01, C_B}, {LDC_LD_AUX, 8'hCC, 8'h01, C_B},
        {LDC_LD_AUX, 8'hD0, 8'h01, C_B}, {LDC_LD_AUX, 8'hD1, 8'h01, C_B},
        {LDC_LD_AUX, 8'hD2, 8'h01, C_B}, {LDC_LD_AUX, 8'hD3, 8'h01, C_B},
        {LDC_LD_AUX, 8'hD4, 8'h01, C_B}, {LDC_LD_AUX, 8'hD5, 8'h01, C_B},
        {LDC_LD_AUX, 8'hD6, 8'h01, C_B}, {LDC_LD_AUX, 8'hD7, 8'h01, C_B},
        {LDC_LD_AUX, 8'hE0, 8'h01, C_B}
    };
    // ----------------------------------------------------------------
    // Table positions that drive outputs or that the assertions check
    // ----------------------------------------------------------------
    localparam int E_PAR_ACT = 0;
    localparam int E_PAR_BASE_HI = 1;
    localparam int E_PAR_BASE_LO = 2;
    localparam int E_PAR_DMA = 4;
    localparam int E_PAR_MODE = 5;
    localparam int E_SER1_ACT = 7;
    localparam int E_SER2_ACT = 12;
    localparam int E_IR_BASE_HI = 15;
    localparam int E_IR_BASE_LO = 16;
    localparam int E_IR_TIMEOUT = 21;
    localparam int E_CLK_ACT = 22;
    localparam int E_KBD_ACT = 27;
    localparam int E_AUX_ACT = 31;
    localparam int E_FWP = 39;
    localparam int E_GPIO_50 = 41;
endpackage

// ### test/ldc_host.sv
// Host processor model that reaches the bank through the index and data ports.
`timescale 1ns/100ps
module ldc_host (
    input  wire logic       clk_sys,
    output logic            cfg_mode,
    output logic      [7:0] ldn,
    output logic      [7:0] index,
    output logic            wr_strobe,
    output logic      [7:0] wr_data,
    output logic            rd_strobe
);
    logic [7:0] expq [$];

    initial begin
        cfg_mode = 1'b0;
        ldn = 8'h00;
        index = 8'h00;
        wr_strobe = 1'b0;
        wr_data = 8'h00;
        rd_strobe = 1'b0;
    end

    task automatic enter(input logic on);
        @(negedge clk_sys);
        cfg_mode = on;
    endtask

    // The data line is inverted after each write so a stale byte never looks valid.
    task automatic put(input logic [7:0] ld, input logic [7:0] idx, input logic wr,
                       input logic [7:0] dat);
        @(negedge clk_sys);
        ldn = ld;
        index = idx;
        wr_data = dat;
        wr_strobe = wr;
        rd_strobe = ~wr;
        @(negedge clk_sys);
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        wr_data = ~dat;
    endtask

    task automatic wr(input logic [7:0] ld, input logic [7:0] idx, input logic [7:0] dat);
        put(ld, idx, 1'b1, dat);
    endtask

    // Outside configuration mode no answer is due, so nothing is noted.
    task automatic rd(input logic [7:0] ld, input logic [7:0] idx, input logic [7:0] exp);
        if (cfg_mode === 1'b1)
            expq.push_back(exp);
        put(ld, idx, 1'b0, 8'h00);
    endtask
endmodule

// ### test/ldc_bank_bench.sv
// Self-checking bench of the logical device configuration bank.
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module ldc_bank_bench;
    import ldc_pkg::*;
    logic        clk_sys = 1'b0;
    logic [4:0]  rst_set = 5'h0F;
    logic [2:0]  shadow_load = 3'h0;
    logic [23:0] shadow_data = 24'h000000;
    logic [15:0] r = 16'h3329;
    int          mismatches = 0;
    int          check_count = 0;
    logic [7:0]  want;
    wire logic        cfg_mode, wr_strobe, rd_strobe, rd_valid;
    wire logic [7:0]  ldn, index, wr_data, rd_data, par_mode, infrared_duplex_timeout, fwp;
    wire logic [5:0]  dev_active;
    wire logic [15:0] par_base_addr, infrared_base_addr;

    always #2.5 clk_sys = ~clk_sys;

    ldc_host host (.clk_sys(clk_sys), .cfg_mode(cfg_mode), .ldn(ldn), .index(index),
        .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe));

    ldc_bank DUT (.clk_sys(clk_sys), .reset(rst_set[0]), .vcc_por(rst_set[1]),
        .vtr_por(rst_set[2]), .vbat_por(rst_set[3]), .soft_reset(rst_set[4]),
        .cfg_mode(cfg_mode), .ldn(ldn), .index(index), .wr_strobe(wr_strobe),
        .wr_data(wr_data), .rd_strobe(rd_strobe), .shadow_load(shadow_load),
        .shadow_data(shadow_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .dev_active(dev_active), .par_base_addr(par_base_addr), .par_mode(par_mode),
        .infrared_base_addr(infrared_base_addr),
        .infrared_duplex_timeout(infrared_duplex_timeout),
        .floppy_write_protect_force(fwp));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // ----------------------------------------------------------------
    // Closing report and answer monitor
    // ----------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(negedge clk_sys) begin
        if (rd_valid === 1'b1) begin
            if (host.expq.size() == 0) begin
                mismatches++;
                $display("mismatch at %0t: read answer nobody asked for", $time);
            end else begin
                want = host.expq.pop_front();
                `CHK(rd_data, want)
            end
        end
    end

    // Bit order follows the reset classes: hard, main, trickle, battery, soft.
    task automatic pulse(input logic [4:0] which);
        @(negedge clk_sys);
        rst_set = which;
        @(negedge clk_sys);
        rst_set = 5'h00;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        $display("mismatch at %0t: run timed out", $time);
        stop_test();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(negedge clk_sys);
        rst_set = 5'h00;
        host.enter(1'b1);
        foreach (LDC_TABLE[i])
            host.rd(LDC_TABLE[i][28:21], LDC_TABLE[i][20:13], LDC_TABLE[i][12:5]);
        host.rd(LDC_LD_PAR, 8'hF0, 8'h3C);
        host.rd(LDC_LD_SER2, 8'hF2, 8'h03);
        r = lfsr(r);
        host.wr(LDC_LD_PAR, 8'h60, r[15:8]);
        host.wr(LDC_LD_PAR, 8'h61, r[7:0]);
        host.wr(LDC_LD_PAR, 8'hF0, r[7:0]);
        host.wr(LDC_LD_SER2, 8'h62, 8'hA5);
        host.wr(LDC_LD_SER2, 8'h63, 8'h5A);
        host.wr(LDC_LD_SER2, 8'hF2, 8'hC3);
        for (int i = 0; i < 6; i++)
            host.wr(LDC_LD_PAR + 8'(i), 8'h30, 8'h01);
        @(negedge clk_sys);
        `CHK(par_base_addr, r)
        `CHK(infrared_base_addr, 16'hA55A)
        `CHK(dev_active, 6'h3F)
        pulse(5'h10);
        @(negedge clk_sys);
        `CHK(par_mode, r[7:0])
        `CHK(infrared_duplex_timeout, 8'hC3)
        `CHK(infrared_base_addr, 16'h0000)
        `CHK(par_base_addr, 16'h0000)
        host.wr(LDC_LD_AUX, 8'hC5, r[15:8]);
        host.wr(LDC_LD_AUX, 8'hC8, 8'h7E);
        pulse(5'h04);
        @(negedge clk_sys);
        `CHK(fwp, r[15:8])
        `CHK(infrared_duplex_timeout, 8'h03)
        pulse(5'h03);
        @(negedge clk_sys);
        `CHK(fwp, 8'h00)
        host.rd(LDC_LD_AUX, 8'hC8, 8'h7E);
        pulse(5'h08);
        host.rd(LDC_LD_AUX, 8'hC8, 8'h01);
        r = lfsr(r);
        @(negedge clk_sys);
        shadow_data = {r[7:0], r[15:8], r[7:0] ^ 8'h3C};
        shadow_load = 3'h7;
        // The first read lands in the cycle right after the load.
        fork
            host.rd(LDC_LD_AUX, 8'hC2, r[7:0] ^ 8'h3C);
            begin
                @(negedge clk_sys);
                shadow_load = 3'h0;
                shadow_data = ~shadow_data;
            end
        join
        host.wr(LDC_LD_AUX, 8'hC2, ~(r[7:0] ^ 8'h3C));
        host.rd(LDC_LD_AUX, 8'hC2, r[7:0] ^ 8'h3C);
        host.rd(LDC_LD_AUX, 8'hC3, r[15:8]);
        host.rd(LDC_LD_AUX, 8'hC4, r[7:0]);
        host.wr(LDC_LD_AUX, 8'hC7, 8'hFF);
        host.rd(LDC_LD_AUX, 8'hC7, 8'h00);
        host.rd(LDC_LD_PAR, 8'h62, 8'h00);
        host.enter(1'b0);
        host.wr(LDC_LD_PAR, 8'hF0, ~r[7:0]);
        host.rd(LDC_LD_PAR, 8'hF0, 8'h00);
        @(negedge clk_sys);
        `CHK(par_mode, 8'h3C)
        for (int k = 0; k < 20 && host.expq.size() != 0; k++)
            @(negedge clk_sys);
        `CHK(host.expq.size(), 0)
        stop_test();
    end
endmodule
